// [hdl/pcidr_pkg.sv]
// Purpose: shared constants, types and state layout of the delayed-read bridge
// Assumes: cycle counts are in ref_clk periods, core periods are enable ticks
// Notes:   one 32-bit slot per interface register, core words are 16 bits
package pcidr_pkg;
  // ----------------------------------------------------------------
  // bus commands and address windows
  // ----------------------------------------------------------------
  localparam logic [3:0]  CMD_MEM_RD   = 4'h6;   // memory read
  localparam logic [3:0]  CMD_MEM_WR   = 4'h7;   // memory write
  localparam logic [3:0]  CMD_MWI      = 4'hf;   // write and invalidate
  localparam logic [16:0] REG_WIN_LAST = 17'h000fc; // core register window end
  localparam logic [16:0] IFREG_FIRST  = 17'h00800; // interface registers start
  localparam logic [16:0] IFREG_LAST   = 17'h0081c; // interface registers end
  localparam int unsigned IFREG_CNT    = 8;      // interface register count
  localparam logic [31:0] IFREG_RST    = 32'h0;  // interface register reset
  localparam int unsigned FLAG_NOT_EMPTY = 30;   // write queue holds data
  localparam int unsigned FLAG_OVERRUN   = 29;   // contention beyond limit
  localparam int unsigned ENH_CFG_BIT    = 14;   // core config bit, kept in core
  // ----------------------------------------------------------------
  // write queue geometry
  // ----------------------------------------------------------------
  localparam int unsigned FIFO_DEPTH = 16;       // one 16-Dword burst
  localparam int unsigned FIFO_AW    = 4;        // pointer width
  // ----------------------------------------------------------------
  // completion timing, bus clocks and core ticks
  // ----------------------------------------------------------------
  localparam logic [6:0] DW_PCI_MIN   = 7'h0d;   // 13 bus clocks
  localparam logic [6:0] DW_CORE_MIN  = 7'h0b;   // 11 core clocks
  localparam logic [6:0] DW_PCI_MAX   = 7'h10;   // 16 bus clocks
  localparam logic [6:0] DW_CORE_MAX  = 7'h0e;   // 14 core clocks
  localparam logic [6:0] SW_PCI_MIN   = 7'h08;   // 8 bus clocks
  localparam logic [6:0] SW_CORE_MIN  = 7'h05;   // 5 core clocks
  localparam logic [6:0] SW_PCI_MAX   = 7'h0a;   // 10 bus clocks
  localparam logic [6:0] SW_CORE_MAX  = 7'h06;   // 6 core clocks
  localparam logic [6:0] ZERO_PCI     = 7'h03;   // zero read, 3 bus clocks
  localparam logic [6:0] EXTRA_ENH_SW = 7'h03;   // contention, fast, 1 word
  localparam logic [6:0] EXTRA_ENH_DW = 7'h06;   // contention, fast, 2 words
  localparam logic [6:0] EXTRA_STD_SW = 7'h43;   // contention, slow, 1 word
  localparam logic [6:0] EXTRA_STD_DW = 7'h4a;   // contention, slow, 2 words
  // ----------------------------------------------------------------
  // enums and carriers
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    RD_IDLE  = 2'h0,   // nothing queued
    RD_PRE   = 2'h1,   // bus-side setup
    RD_CORE  = 2'h2,   // core word accesses
    RD_READY = 2'h3    // data waits for the repeat
  } pcidr_rd_e;
  typedef enum logic [2:0] {
    RSP_NONE   = 3'h0,
    RSP_ACCEPT = 3'h1, // write taken
    RSP_RETRY  = 3'h2, // retry termination
    RSP_DATA   = 3'h3, // disconnect with data
    RSP_ABORT  = 3'h4  // target abort
  } pcidr_rsp_e;
  typedef struct packed {
    logic        valid;   // held until done
    logic [3:0]  cmd;     // bus command
    logic        bar1;    // 0 core memory, 1 register region
    logic [16:0] off;     // byte offset in region
    logic [3:0]  byte_lane_enables_n; // active low lanes
    logic [31:0] wdata;
  } pcidr_req_s;
  typedef struct packed {
    logic        done;    // one-cycle end of transaction
    pcidr_rsp_e  kind;
    logic [31:0] rdata;
  } pcidr_rsp_s;
  typedef struct packed {
    logic        req;     // access active
    logic        write;
    logic        is_reg;
    logic [15:0] addr;    // word address
    logic [15:0] wdata;
  } pcidr_core_s;
  typedef struct packed {
    logic        is_reg;
    logic [15:0] addr;    // low word address
    logic        we_lo;
    logic        we_hi;
    logic [31:0] data;
  } pcidr_ent_s;
  typedef struct packed {
    logic        valid;
    logic        bar1;
    logic [14:0] dwa;     // Dword offset
    logic [3:0]  be_n;
    logic        dw;      // two-word read
    logic        hi_only; // upper word only
  } pcidr_pend_s;
  typedef struct packed {
    logic [FIFO_AW-1:0] wp;
    logic [FIFO_AW-1:0] rp;
    logic [FIFO_AW:0]   cnt;
  } pcidr_fifo_st_s;
  typedef struct packed {
    pcidr_rd_e   rd;
    logic [6:0]  cnt;     // setup clocks or word ticks
    logic [6:0]  stall;   // ticks lost to contention
    logic        hi;      // word in progress
    pcidr_pend_s pend;
    logic [31:0] rdata;
    pcidr_rsp_s  rsp;
    logic [6:0]  zcnt;    // zero read clocks
    logic        overrun;
    logic        drain_hi;
    logic [IFREG_CNT-1:0][31:0] ifreg;
  } pcidr_st_s;
endpackage : pcidr_pkg

// [hdl/pcidr_wfifo.sv]
// Purpose: write queue between the bus side and the core drain
// Assumes: one push and one pop per clock at most
// Notes:   storage holds no reset, only pointers and fill count do
`timescale 1ns/1ps
module pcidr_wfifo (
  input  wire logic              ref_clk,
  input  wire logic              arst_n,
  input  wire logic              clk_en,
  input  wire logic              in_valid,
  output logic                   in_ready,
  input  wire pcidr_pkg::pcidr_ent_s in_data,
  output logic                   out_valid,
  input  wire logic              out_ready,
  output pcidr_pkg::pcidr_ent_s  out_data
);
  pcidr_pkg::pcidr_fifo_st_s s_reg;   // pointers and fill
  pcidr_pkg::pcidr_fifo_st_s s_next;
  pcidr_pkg::pcidr_ent_s mem [pcidr_pkg::FIFO_DEPTH]; // entry storage
  logic push;
  logic pop;

  // honest full and empty from the fill count
  assign in_ready  = (s_reg.cnt != (pcidr_pkg::FIFO_AW+1)'(pcidr_pkg::FIFO_DEPTH));
  assign out_valid = (s_reg.cnt != '0);
  assign out_data  = mem[s_reg.rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // ----------------------------------------------------------------
  // pointer update
  // ----------------------------------------------------------------
  always_comb
  begin
    s_next = s_reg;
    if (push)
    begin
      s_next.wp = s_reg.wp + 1'b1;
    end
    if (pop)
    begin
      s_next.rp = s_reg.rp + 1'b1;
    end
    s_next.cnt = s_reg.cnt + {4'h0, push} - {4'h0, pop};
  end

  // state register, frozen with clk_en low
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_reg <= '0;
    end
    else if (clk_en)
    begin
      s_reg <= s_next;
    end
  end

  // storage write, no reset needed
  always_ff @(posedge ref_clk)
  begin
    if (clk_en && push)
    begin
      mem[s_reg.wp] <= in_data;
    end
  end
endmodule : pcidr_wfifo

// [hdl/pcidr_bridge.sv]
// Purpose: bus target with write queue and delayed reads toward a 16-bit core
// Assumes: master holds req.valid until rsp.done and drops it the next edge
// Notes:   core clock arrives as a tick enable, contention as grant low
`timescale 1ns/1ps
// Contract
// - double-word memory read: at least 13+11 clocks
// - uncontested double-word read: at most 16+14 clocks
// - single word or register read: 8+5 to 10+6
// - empty or upper-register read: three clocks, zeroes
// - fast access option adds 3 or 6 ticks
// - slow access adds 67 or 74 ticks
// - core memory and register writes enter queue
// - interface register writes bypass queue directly
// - accept 16 Dword burst when room exists
// - single byte in memory word: target abort
// - single byte in register word: target abort
// - register upper-word-only writes change nothing
// - write-and-invalidate behaves as plain write
// - queue read only if empty, none pending
// - otherwise answer retry, queue nothing
// - repeats retried until data, then disconnect
// - queue-not-empty flag at bit 30
module pcidr_bridge (
  input  wire logic                  ref_clk,
  input  wire logic                  arst_n,
  input  wire logic                  clk_en,
  input  wire pcidr_pkg::pcidr_req_s req,
  output pcidr_pkg::pcidr_rsp_s      rsp,
  input  wire logic                  terminal_core_clock,   // core tick
  input  wire logic                  core_grant,
  input  wire logic                  enhanced_host_access,
  input  wire logic [15:0]           core_rdata,
  output pcidr_pkg::pcidr_core_s     core
);
  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  pcidr_pkg::pcidr_st_s  s_reg;     // all state
  pcidr_pkg::pcidr_st_s  s_next;
  pcidr_pkg::pcidr_ent_s push_ent;  // entry being written
  pcidr_pkg::pcidr_ent_s head;      // oldest entry
  logic       push;
  logic       room;
  logic       head_vld;
  logic       pop;
  logic       take;                 // request seen this cycle
  logic       is_wr;
  logic       is_ifr;
  logic       is_creg;
  logic       is_mem;
  logic [3:0] be;                   // active-high lanes
  logic       drain;                // queue owns the core
  logic       step;                 // core tick with grant
  logic       half_hi;              // drain word select
  logic       match;

  // one byte alone in either word
  function automatic logic partial(input logic [3:0] b);
    partial = (b[1] ^ b[0]) | (b[3] ^ b[2]);
  endfunction : partial

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  assign take   = req.valid && !s_reg.rsp.done;
  assign is_wr  = (req.cmd == pcidr_pkg::CMD_MEM_WR)
               || (req.cmd == pcidr_pkg::CMD_MWI);
  assign be     = ~req.byte_lane_enables_n;
  assign is_ifr = req.bar1 && (req.off >= pcidr_pkg::IFREG_FIRST)
               && (req.off <= pcidr_pkg::IFREG_LAST);
  assign is_creg = req.bar1 && (req.off <= pcidr_pkg::REG_WIN_LAST);
  assign is_mem  = !req.bar1;
  assign match   = s_reg.pend.valid && (s_reg.pend.bar1 == req.bar1)
                && (s_reg.pend.dwa == req.off[16:2])
                && (s_reg.pend.be_n == req.byte_lane_enables_n);
  assign step    = terminal_core_clock && core_grant;
  assign drain   = head_vld && ((s_reg.rd == pcidr_pkg::RD_IDLE)
                || (s_reg.rd == pcidr_pkg::RD_READY));
  assign half_hi = s_reg.drain_hi || !head.we_lo;
  assign pop     = drain && step && (half_hi || !head.we_hi);

  // upper lanes never reach a core register
  always_comb
  begin
    push_ent.is_reg = is_creg;
    push_ent.addr   = is_creg ? {10'h0, req.off[7:2]} : {req.off[16:2], 1'b0};
    push_ent.we_lo  = (be[1:0] != 2'h0);
    push_ent.we_hi  = (be[3:2] != 2'h0) && !is_creg;
    push_ent.data   = req.wdata;
  end

  // ----------------------------------------------------------------
  // write queue
  // ----------------------------------------------------------------
  pcidr_wfifo u_wfifo (
    .ref_clk   (ref_clk),
    .arst_n    (arst_n),
    .clk_en    (clk_en),
    .in_valid  (push),
    .in_ready  (room),
    .in_data   (push_ent),
    .out_valid (head_vld),
    .out_ready (pop),
    .out_data  (head)
  );

  // core port from flops; a read never overlaps the drain
  always_comb
  begin
    core = '0;
    if (s_reg.rd == pcidr_pkg::RD_CORE)
    begin
      core.req    = 1'b1;
      core.is_reg = s_reg.pend.bar1;
      core.addr   = s_reg.pend.bar1 ? {10'h0, s_reg.pend.dwa[5:0]}
                                    : {s_reg.pend.dwa, s_reg.hi};
    end
    else if (drain)
    begin
      core.req    = 1'b1;
      core.write  = 1'b1;
      core.is_reg = head.is_reg;
      core.addr   = head.addr | {15'h0, half_hi};
      core.wdata  = half_hi ? head.data[31:16] : head.data[15:0];
    end
  end
  assign rsp = s_reg.rsp;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_next          = s_reg;
    s_next.rsp.done = 1'b0;
    s_next.rsp.kind = pcidr_pkg::RSP_NONE;
    push            = 1'b0;
    // drain bookkeeping
    if (drain && step)
    begin
      s_next.drain_hi = !pop;
    end
    // delayed read engine
    unique case (s_reg.rd)
      pcidr_pkg::RD_IDLE: ;
      pcidr_pkg::RD_PRE:
      begin
        s_next.cnt = s_reg.cnt + 7'h01;
        if (s_reg.cnt == (s_reg.pend.dw ? pcidr_pkg::DW_PCI_MIN : pcidr_pkg::SW_PCI_MIN)
                         - 7'h01)
        begin
          s_next.rd  = pcidr_pkg::RD_CORE;
          s_next.cnt = 7'h00;
        end
      end
      pcidr_pkg::RD_CORE:
      begin
        if (terminal_core_clock && !core_grant)
        begin
          s_next.stall = s_reg.stall + 7'h01;
          // contention ceiling depends on the access option
          if (s_reg.stall >= (enhanced_host_access
              ? (s_reg.pend.dw ? pcidr_pkg::EXTRA_ENH_DW : pcidr_pkg::EXTRA_ENH_SW)
              : (s_reg.pend.dw ? pcidr_pkg::EXTRA_STD_DW : pcidr_pkg::EXTRA_STD_SW)))
          begin
            s_next.overrun = 1'b1;
          end
        end
        if (step)
        begin
          s_next.cnt = s_reg.cnt + 7'h01;
          // first word 5 ticks, second word the rest of 11
          if (s_reg.cnt == (s_reg.hi && s_reg.pend.dw
              ? pcidr_pkg::DW_CORE_MIN - pcidr_pkg::SW_CORE_MIN
              : pcidr_pkg::SW_CORE_MIN) - 7'h01)
          begin
            s_next.cnt = 7'h00;
            if (s_reg.hi)
            begin
              s_next.rdata[31:16] = core_rdata;
            end
            else
            begin
              s_next.rdata[15:0] = core_rdata;
            end
            if (s_reg.pend.dw && !s_reg.hi)
            begin
              s_next.hi = 1'b1;
            end
            else
            begin
              s_next.rd = pcidr_pkg::RD_READY;
            end
          end
        end
      end
      pcidr_pkg::RD_READY: ;
    endcase
    // bus request
    if (take)
    begin
      s_next.rsp.done  = 1'b1;
      s_next.rsp.rdata = 32'h0;
      if (is_wr && is_ifr)
      begin
        // direct register write, status bits not stored, a one at bit 29 clears overrun outside RD_CORE
        for (int b = 0; b < 4; b++)
        begin
          if (be[b])
          begin
            s_next.ifreg[req.off[4:2]][b*8 +: 8] = req.wdata[b*8 +: 8];
          end
        end
        s_next.ifreg[req.off[4:2]][pcidr_pkg::FLAG_NOT_EMPTY] = 1'b0;
        s_next.ifreg[req.off[4:2]][pcidr_pkg::FLAG_OVERRUN]   = 1'b0;
        if ((req.off[4:2] == 3'h0) && req.wdata[pcidr_pkg::FLAG_OVERRUN] && be[3]
            && !s_next.overrun)
        begin
          s_next.overrun = 1'b0;
        end
        else if ((req.off[4:2] == 3'h0) && req.wdata[pcidr_pkg::FLAG_OVERRUN] && be[3]
                 && s_reg.rd != pcidr_pkg::RD_CORE)
        begin
          s_next.overrun = 1'b0;
        end
        s_next.rsp.kind = pcidr_pkg::RSP_ACCEPT;
      end
      else if (is_wr && (is_mem || is_creg))
      begin
        if (partial(be))
        begin
          s_next.rsp.kind = pcidr_pkg::RSP_ABORT;
        end
        else if (!room)
        begin
          s_next.rsp.kind = pcidr_pkg::RSP_RETRY;
        end
        else
        begin
          push = push_ent.we_lo || push_ent.we_hi;
          s_next.rsp.kind = pcidr_pkg::RSP_ACCEPT;
        end
      end
      else if (!is_wr && req.cmd == pcidr_pkg::CMD_MEM_RD && is_ifr)
      begin
        s_next.rsp.rdata = s_reg.ifreg[req.off[4:2]];
        if (req.off[4:2] == 3'h0)
        begin
          s_next.rsp.rdata[pcidr_pkg::FLAG_NOT_EMPTY] = head_vld;
          s_next.rsp.rdata[pcidr_pkg::FLAG_OVERRUN]   = s_reg.overrun;
        end
        s_next.rsp.kind = pcidr_pkg::RSP_DATA;
      end
      else if (!is_wr && req.cmd == pcidr_pkg::CMD_MEM_RD && is_creg && partial(be))
      begin
        s_next.rsp.kind = pcidr_pkg::RSP_ABORT;
      end
      else if (!is_wr && req.cmd == pcidr_pkg::CMD_MEM_RD && (is_mem || is_creg)
               && (be == 4'h0 || (is_creg && be[1:0] == 2'h0)))
      begin
        // zero read: hold the master for three clocks
        s_next.zcnt     = s_reg.zcnt + 7'h01;
        s_next.rsp.done = (s_reg.zcnt == pcidr_pkg::ZERO_PCI - 7'h01);
        if (s_next.rsp.done)
        begin
          s_next.zcnt     = 7'h00;
          s_next.rsp.kind = pcidr_pkg::RSP_DATA;
        end
      end
      else if (!is_wr && req.cmd == pcidr_pkg::CMD_MEM_RD && (is_mem || is_creg))
      begin
        s_next.rsp.kind = pcidr_pkg::RSP_RETRY;
        if (match && s_reg.rd == pcidr_pkg::RD_READY)
        begin
          s_next.rsp.kind  = pcidr_pkg::RSP_DATA;
          s_next.rsp.rdata = s_reg.rdata;
          s_next.pend      = '0;
          s_next.rd        = pcidr_pkg::RD_IDLE;
        end
        else if (!s_reg.pend.valid && !head_vld && s_reg.rd == pcidr_pkg::RD_IDLE)
        begin
          s_next.pend.valid   = 1'b1;
          s_next.pend.bar1    = req.bar1;
          s_next.pend.dwa     = req.off[16:2];
          s_next.pend.be_n    = req.byte_lane_enables_n;
          s_next.pend.dw      = is_mem && (be[1:0] != 2'h0) && (be[3:2] != 2'h0);
          s_next.pend.hi_only = is_mem && (be[1:0] == 2'h0);
          s_next.hi           = is_mem && (be[1:0] == 2'h0);
          s_next.rd           = pcidr_pkg::RD_PRE;
          s_next.cnt          = 7'h00;
          s_next.stall        = 7'h00;
          s_next.rdata        = 32'h0;
        end
      end
      else
      begin
        s_next.rsp.kind = pcidr_pkg::RSP_ABORT; // unmapped or unknown command
      end
    end
  end

  // state register, frozen with clk_en low
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_reg       <= '0;
      s_reg.ifreg <= {pcidr_pkg::IFREG_CNT{pcidr_pkg::IFREG_RST}};
    end
    else if (clk_en)
    begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n || !clk_en);

  logic [7:0] hl_pre;   // setup clocks of the current read
  logic [7:0] hl_tick;  // granted ticks of the current read
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      hl_pre  <= 8'h00;
      hl_tick <= 8'h00;
    end
    else if (clk_en && s_next.rd == pcidr_pkg::RD_PRE && s_reg.rd == pcidr_pkg::RD_IDLE)
    begin
      hl_pre  <= 8'h00;
      hl_tick <= 8'h00;
    end
    else if (clk_en)
    begin
      hl_pre  <= hl_pre + {7'h0, s_reg.rd == pcidr_pkg::RD_PRE};
      hl_tick <= hl_tick + {7'h0, s_reg.rd == pcidr_pkg::RD_CORE && step};
    end
  end

  sequence seq_zero_take;
    take && !is_wr && is_creg && be == 4'hc && s_reg.zcnt == 7'h00;
  endsequence
  sequence seq_zero_end;
    !rsp.done ##1 rsp.done && rsp.kind == pcidr_pkg::RSP_DATA && rsp.rdata == 32'h0;
  endsequence

  AST_ZERO_THREE: assert property (seq_zero_take ##0 req.valid [*2] |=> seq_zero_end)
    else $error("zero read not finished in three clocks");
  AST_DW_MIN: assert property ($rose(s_reg.rd == pcidr_pkg::RD_READY) && s_reg.pend.dw
    |-> hl_pre >= 8'd13 && hl_tick >= 8'd11)
    else $error("double-word read finished early");
  AST_DW_MAX: assert property ($rose(s_reg.rd == pcidr_pkg::RD_READY) && s_reg.pend.dw
    && s_reg.stall == 7'h00 |-> hl_pre <= 8'd16 && hl_tick <= 8'd14)
    else $error("uncontested double-word read too slow");
  AST_SW_WINDOW: assert property ($rose(s_reg.rd == pcidr_pkg::RD_READY) && !s_reg.pend.dw
    |-> hl_pre inside {[8'd8:8'd10]} && hl_tick inside {[8'd5:8'd6]})
    else $error("single-word read outside its window");
  AST_QUEUE_EMPTY: assert property ($rose(s_reg.rd == pcidr_pkg::RD_PRE)
    |-> !$past(head_vld) && !$past(s_reg.pend.valid))
    else $error("read queued behind writes or a pending read");
  AST_RETRY_BUSY: assert property (take && !is_wr && is_mem && be == 4'hf && head_vld
    |=> rsp.done && rsp.kind == pcidr_pkg::RSP_RETRY && $stable(s_reg.pend))
    else $error("busy read not retried");
  AST_DISC_DATA: assert property (take && !is_wr && is_mem && be == 4'hf && match
    && s_reg.rd == pcidr_pkg::RD_READY |=> rsp.kind == pcidr_pkg::RSP_DATA
    && rsp.rdata == $past(s_reg.rdata) && s_reg.rd == pcidr_pkg::RD_IDLE)
    else $error("ready read not completed with data");
  AST_ABORT_BYTE: assert property (take && is_wr && (is_mem || is_creg) && partial(be)
    |-> !push ##1 rsp.done && rsp.kind == pcidr_pkg::RSP_ABORT)
    else $error("single-byte write not aborted");
  AST_IFREG_DIRECT: assert property (take && is_wr && is_ifr
    |-> !push ##1 rsp.kind == pcidr_pkg::RSP_ACCEPT)
    else $error("interface write went through the queue");
  AST_MWI_ALIAS: assert property (take && req.cmd == pcidr_pkg::CMD_MWI && is_mem
    && be == 4'hf && room |-> push ##1 rsp.kind == pcidr_pkg::RSP_ACCEPT)
    else $error("write-and-invalidate not queued as a write");
  AST_REG_UPPER: assert property (take && is_wr && is_creg && be == 4'hc |-> !push)
    else $error("upper-word register write reached the queue");
  AST_FLAG_BIT: assert property (take && !is_wr && is_ifr && req.off[4:2] == 3'h0
    |=> rsp.rdata[30] == $past(head_vld))
    else $error("queue flag wrong");
endmodule : pcidr_bridge

// [dv/pcidr_core_model.sv]
// Purpose: behavioural terminal core behind the bridge's core port
// Assumes: core period is four ref_clk cycles, grant comes from the testbench
// Notes:   read data is the word address mixed with a fixed pattern
`timescale 1ns/1ps
module pcidr_core_model (
  input  wire logic                   ref_clk,
  input  wire logic                   arst_n,
  input  wire pcidr_pkg::pcidr_core_s core,
  output logic                        tick,
  output logic [15:0]                 rdata
);
  logic [1:0]  div_reg;      // core period divider
  logic [15:0] mem [0:63];   // write log, low address bits only
  // one tick every four cycles, free running like a real core clock
  always_ff @(posedge ref_clk or negedge arst_n)
    if (!arst_n)
      div_reg <= 2'h0;
    else
      div_reg <= div_reg + 2'h1;
  assign tick = (div_reg == 2'h3);
  // no read selected: a changing pattern, so stale data never matches
  assign rdata = (core.req && !core.write) ? (core.addr ^ 16'h3c3c) : {8{div_reg}};
  // completed drain words land in arrival order
  always_ff @(posedge ref_clk)
    if (core.req && core.write && tick)
      mem[core.addr[5:0]] <= core.wdata;
endmodule : pcidr_core_model

// [dv/pcidr_bridge_tb.sv]
// Purpose: directed checks of the delayed-read bridge
// Assumes: one request outstanding, valid dropped after done
// Notes:   grant and access option driven here, contention held by grant low
`timescale 1ns/1ps
module pcidr_bridge_tb;
  logic                   ref_clk = 1'b0;
  logic                   arst_n  = 1'b0;
  pcidr_pkg::pcidr_req_s  req     = '0;
  pcidr_pkg::pcidr_rsp_s  rsp;
  pcidr_pkg::pcidr_core_s core;
  logic                   tick;
  logic [15:0]            crd;
  logic                   gnt     = 1'b1; // core RAM free
  logic                   enh     = 1'b1; // fast access option
  logic [2:0]             k;     // answer kind
  logic [31:0]            d;     // answer data
  int                     n;     // edges to done
  int                     s;
  int err_count = 0;
  int total_checks = 0;
  int cyc = 0;
  always #50 ref_clk = ~ref_clk;
  pcidr_bridge u_dut (.ref_clk(ref_clk), .arst_n(arst_n), .clk_en(1'b1), .req(req),
    .rsp(rsp), .terminal_core_clock(tick), .core_grant(gnt),
    .enhanced_host_access(enh), .core_rdata(crd), .core(core));
  pcidr_core_model u_core (.ref_clk(ref_clk), .arst_n(arst_n), .core(core),
    .tick(tick), .rdata(crd));
  // hang guard, the whole run needs well under a thousand cycles
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      tally_and_finish();
    end
  end
  // one bus transfer, held until done, then released
  task bus(input logic [3:0] c, input logic b, input logic [16:0] o,
           input logic [3:0] be, input logic [31:0] w);
    n = 0;
    @(posedge ref_clk);
    #10 req = '{1'b1, c, b, o, be, w};
    do begin @(posedge ref_clk); #10 n++; end while (rsp.done !== 1'b1 && n < 50);
    k = rsp.kind;
    d = rsp.rdata;
    req.valid = 1'b0;
  endtask : bus
  task chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task t_write;
    bus(4'h7, 1'b0, 17'h10, 4'h0, 32'h11112222);
    chk(k, pcidr_pkg::RSP_ACCEPT);
    chk(n, 1);
    // sixteen Dwords back to back, all must be taken
    for (int i = 0; i < 16; i++)
    begin
      bus(4'h7, 1'b0, 17'h40 + 17'(4 * i), 4'h0, 32'h0);
      chk(k, pcidr_pkg::RSP_ACCEPT);
    end
    bus(4'h6, 1'b0, 17'h40, 4'h0, 32'h0);
    chk(k, pcidr_pkg::RSP_RETRY);
    bus(4'hf, 1'b0, 17'h10, 4'h0, 32'h33334444);
    chk(k, pcidr_pkg::RSP_ACCEPT);
    bus(4'h6, 1'b1, 17'h800, 4'h0, 32'h0);
    chk(d[30], 1'b1);
    for (int i = 0; i < 100 && d[30]; i++) bus(4'h6, 1'b1, 17'h800, 4'h0, 32'h0);
    chk({u_core.mem[9], u_core.mem[8]}, 32'h33334444);
    $display("test write done");
  endtask : t_write
  task t_misc;
    // bits 30 and 29 stay clear, they are status positions
    bus(4'h7, 1'b1, 17'h804, 4'h0, 32'h9afe0001);
    chk(k, pcidr_pkg::RSP_ACCEPT);
    bus(4'h6, 1'b1, 17'h804, 4'h0, 32'h0);
    chk(d, 32'h9afe0001);
    bus(4'h7, 1'b0, 17'h20, 4'he, 32'h0);
    chk(k, pcidr_pkg::RSP_ABORT);
    bus(4'h7, 1'b1, 17'h8, 4'hd, 32'h0);
    chk(k, pcidr_pkg::RSP_ABORT);
    bus(4'h6, 1'b0, 17'h40, 4'hf, 32'h0);
    chk(k, pcidr_pkg::RSP_DATA);
    chk(d, 32'h0);
    chk(n, 3);
    // register upper word: write dropped, read gives zeroes
    bus(4'h7, 1'b1, 17'h8, 4'h3, 32'h12345678);
    chk(k, pcidr_pkg::RSP_ACCEPT);
    bus(4'h6, 1'b1, 17'h8, 4'h3, 32'h0);
    chk(k, pcidr_pkg::RSP_DATA);
    chk(d, 32'h0);
    chk(n, 3);
    $display("test misc done");
  endtask : t_misc
  task t_dread;
    s = cyc;
    bus(4'h6, 1'b0, 17'h40, 4'h0, 32'h0);
    chk(k, pcidr_pkg::RSP_RETRY);
    while (k == pcidr_pkg::RSP_RETRY && cyc - s < 300) bus(4'h6, 1'b0, 17'h40, 4'h0, 32'h0);
    chk(k, pcidr_pkg::RSP_DATA);
    chk(d, {16'h0021 ^ 16'h3c3c, 16'h0020 ^ 16'h3c3c});
    chk(cyc - s >= 57, 1'b1);
    chk(cyc - s <= 80, 1'b1);
    $display("test delayed read done");
  endtask : t_dread
  // repeat one core read until the bridge stops retrying
  task rd_wait(input logic [16:0] o, input logic [3:0] be);
    s = cyc;
    while (k == pcidr_pkg::RSP_RETRY && cyc - s < 300) bus(4'h6, 1'b0, o, be, 32'h0);
  endtask : rd_wait
  // contention: grant low for sixty clocks, about fifteen core ticks
  task t_stall;
    gnt = 1'b0;
    bus(4'h6, 1'b0, 17'h44, 4'hc, 32'h0);
    repeat (60) @(posedge ref_clk);
    #10 gnt = 1'b1;
    rd_wait(17'h44, 4'hc);
    chk(k, pcidr_pkg::RSP_DATA);
    bus(4'h6, 1'b1, 17'h800, 4'h0, 32'h0);
    chk(d[29], 1'b1);
    bus(4'h7, 1'b1, 17'h800, 4'h0, 32'h20000000);
    // slow option: same stall stays under its ceiling
    enh = 1'b0;
    gnt = 1'b0;
    bus(4'h6, 1'b0, 17'h48, 4'hc, 32'h0);
    repeat (60) @(posedge ref_clk);
    #10 gnt = 1'b1;
    rd_wait(17'h48, 4'hc);
    chk(k, pcidr_pkg::RSP_DATA);
    bus(4'h6, 1'b1, 17'h800, 4'h0, 32'h0);
    chk(d[29], 1'b0);
    $display("test stall done");
  endtask : t_stall
  task tally_and_finish;
    $display("checks=%0d errors=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    repeat (16) @(posedge ref_clk);
    #10 arst_n = 1'b1;
    t_write();
    t_misc();
    t_dread();
    t_stall();
    tally_and_finish();
  end
endmodule : pcidr_bridge_tb
